// ---- rtl/scd_datapath.sv ----
// Sensor and temperature correction datapath with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, and hclk at 50 MHz.
//
// Operation
// - Sensor output clamped to 0..FFFFFF
// - Intermediates saturate to 26-bit signed, flagged
// - Linear stage then curve-selected second stage
// - Gain factor K1 from temperature drift terms
// - Offset summand K2 from offset and drift
// - Parabolic intermediate adds one before saturation
// - Parabolic output with second-order sensor term
// - S-shaped intermediate without the added one
// - S-shaped output uses absolute intermediate value
// - Temperature second order always parabolic
// - Temperature intermediate clamped to 0..2^25-1
// - Corrected temperature clamped to 0..FFFFFF
// - All results presented as 24-bit words
// - Raw readings are two's complement fractions
// - Coefficients are sign-magnitude, 21 fraction bits; the two post offsets are added unscaled, as 23 fraction bits
// - Corrected outputs are unsigned 24-bit fractions
// - Thresholds share the corrected output format
// - Sensor coefficients accept values within 7FFFF; the coefficient registers keep any 23-bit magnitude unchecked
// - Saturation shown in status bit 0
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`default_nettype none
module scd_datapath (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Results toward the host interface
    output logic [23:0]      sensor_result,
    output logic [23:0]      temp_result,
    output logic [7:0]       status_byte,
    output logic             result_valid,
    output logic [23:0]      irq_threshold_one,
    output logic [23:0]      irq_threshold_two
);

    typedef logic signed [25:0] scd_acc_type;

    // Saturate to the signed 26-bit range; bit 26 flags a clip
    function automatic logic [26:0] scd_sat(input logic signed [63:0] x);
        logic [26:0] r;
        r = {1'b0, x[25:0]};
        if (x > scd_pkg::SAT_MAX) begin
            r = {1'b1, scd_pkg::SAT_MAX[25:0]};
        end else if (x < scd_pkg::SAT_MIN) begin
            r = {1'b1, scd_pkg::SAT_MIN[25:0]};
        end
        return r;
    endfunction

    // Clamp to zero through hi; bit 26 flags a clip
    function automatic logic [26:0] scd_clamp(input logic signed [63:0] x,
                                              input logic signed [63:0] hi);
        logic [26:0] r;
        r = {1'b0, x[25:0]};
        if (x > hi) begin
            r = {1'b1, hi[25:0]};
        end else if (x < 64'sh0) begin
            r = {1'b1, 26'h0000000};
        end
        return r;
    endfunction

    // Full-width product, then truncating arithmetic shift
    function automatic logic signed [63:0] scd_mul(input scd_acc_type a,
                                                   input scd_acc_type b,
                                                   input int sh);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return p >>> sh;
    endfunction

    function automatic logic signed [63:0] scd_ext(input scd_acc_type a);
        return 64'(a);
    endfunction

    // Register state
    logic [23:0] coef_reg [scd_pkg::COEF_COUNT];
    logic [23:0] raw_sensor_reg;
    logic [23:0] raw_temp_reg;
    logic        curve_reg;
    logic        start_reg;
    logic        done_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  addr_reg;

    // Bus decode
    wire         addr_phase = hsel & hready & htrans[1];
    wire         wr_data    = wr_pend_reg;
    wire  [7:0]  a_sel      = addr_reg;
    wire         coef_hit   = (a_sel >= scd_pkg::COEF_BASE_OFF) &&
                              (a_sel < scd_pkg::SENSOR_OUT_OFF) && (a_sel[1:0] == 2'b00);
    wire  [3:0]  coef_idx   = 4'((a_sel - scd_pkg::COEF_BASE_OFF) >> 2);
    wire         start_wr   = wr_data && (a_sel == scd_pkg::CTRL_OFF) &&
                              hwdata[scd_pkg::CTRL_START_BIT];

    // Coefficients: sign-magnitude to signed
    scd_acc_type coef_s [scd_pkg::COEF_COUNT];
    genvar gi;
    generate
        for (gi = 0; gi < scd_pkg::COEF_COUNT; gi++) begin : g_coef
            wire [22:0] mag = coef_reg[gi][22:0];
            assign coef_s[gi] = coef_reg[gi][scd_pkg::WORD_MSB] ?
                                -scd_acc_type'({3'b000, mag}) : scd_acc_type'({3'b000, mag});
        end
    endgenerate

    // Raw readings sign-extend, weight 2^-23 per lsb
    wire scd_acc_type sr = scd_acc_type'($signed(raw_sensor_reg));
    wire scd_acc_type tr = scd_acc_type'($signed(raw_temp_reg));

    wire scd_acc_type c_gain  = coef_s[scd_pkg::SENSOR_GAIN_IDX];
    wire scd_acc_type c_off   = coef_s[scd_pkg::SENSOR_OFFSET_IDX];
    wire scd_acc_type c_tcg   = coef_s[scd_pkg::TEMP_GAIN_DRIFT_IDX];
    wire scd_acc_type c_tco   = coef_s[scd_pkg::TEMP_OFFSET_DRIFT_IDX];
    wire scd_acc_type c_tcg2  = coef_s[scd_pkg::TCG_SECOND_IDX];
    wire scd_acc_type c_tco2  = coef_s[scd_pkg::TCO_SECOND_IDX];
    wire scd_acc_type c_sso   = coef_s[scd_pkg::SENSOR_SECOND_IDX];
    wire scd_acc_type c_spost = coef_s[scd_pkg::SENSOR_POST_OFFSET_IDX];
    wire scd_acc_type c_tgain = coef_s[scd_pkg::TEMP_GAIN_IDX];
    wire scd_acc_type c_toff  = coef_s[scd_pkg::TEMP_OFFSET_IDX];
    wire scd_acc_type c_tso   = coef_s[scd_pkg::TEMP_SECOND_IDX];
    wire scd_acc_type c_tpost = coef_s[scd_pkg::TEMP_POST_OFFSET_IDX];

    // Linear stage: gain factor K1
    wire [26:0] k1_a = scd_sat(scd_mul(c_tcg2, tr, scd_pkg::COEF_SHIFT));
    wire [26:0] k1_b = scd_sat(scd_ext(k1_a[25:0]) + 4 * scd_ext(c_tcg));
    wire [26:0] k1_c = scd_sat(scd_mul(tr, k1_b[25:0], scd_pkg::FRAC_SHIFT));
    wire [26:0] k1_w = scd_sat(scd_pkg::ONE_FRAC + scd_ext(k1_c[25:0]));

    // Linear stage: offset summand K2
    wire [26:0] k2_a = scd_sat(scd_mul(c_tco2, tr, scd_pkg::COEF_SHIFT));
    wire [26:0] k2_b = scd_sat(scd_ext(k2_a[25:0]) + 4 * scd_ext(c_tco));
    wire [26:0] k2_c = scd_sat(scd_mul(tr, k2_b[25:0], scd_pkg::FRAC_SHIFT));
    wire [26:0] k2_d = scd_sat(scd_ext(sr) + scd_ext(k2_c[25:0]));
    wire [26:0] k2_w = scd_sat(4 * scd_ext(c_off) + scd_ext(k2_d[25:0]));

    // Intermediate value; the added one depends on the curve
    wire [26:0] z_a  = scd_sat(scd_mul(k1_w[25:0], k2_w[25:0], scd_pkg::FRAC_SHIFT));
    wire signed [63:0] z_p = scd_mul(c_gain, z_a[25:0], scd_pkg::COEF_SHIFT);
    // Parabolic form adds the one before its only bound, so no early clip
    wire [26:0] z_b  = scd_sat(z_p);
    wire [26:0] z_sp = scd_sat(z_p + scd_pkg::ONE_FRAC);
    wire [26:0] z_w  = curve_reg ? z_b : z_sp;
    wire        z_neg = z_w[25];

    // Absolute value clips 2^25 magnitude back into range
    wire [26:0] z_abs = (curve_reg && z_neg) ? scd_sat(-scd_ext(z_w[25:0])) : z_w;

    // Second-order stage
    wire [26:0] s_a  = scd_sat(scd_mul(c_sso, z_abs[25:0], scd_pkg::COEF_SHIFT));
    wire [26:0] s_b  = scd_sat(scd_ext(s_a[25:0]) + scd_pkg::ONE_FRAC);
    wire signed [63:0] s_p  = scd_mul(z_w[25:0], s_b[25:0], scd_pkg::FRAC_SHIFT);
    wire [26:0] s_ps = scd_sat(s_p);
    // Only the S-shaped form bounds this product separately
    wire signed [63:0] s_pu = curve_reg ? scd_ext(s_ps[25:0]) : s_p;
    wire signed [63:0] s_sum = s_pu + scd_ext(c_spost) +
                               (curve_reg ? scd_pkg::ONE_FRAC : 64'sh0);
    wire [26:0] s_w  = scd_clamp(s_sum, scd_pkg::OUT_MAX);

    // The absolute step only clips for the S-shaped curve
    wire        s_abs_sat = curve_reg && z_neg && z_abs[26];
    wire        sensor_sat = k1_a[26] | k1_b[26] | k1_c[26] | k1_w[26] |
                             k2_a[26] | k2_b[26] | k2_c[26] | k2_d[26] | k2_w[26] |
                             z_a[26] | (curve_reg & z_b[26]) | (~curve_reg & z_sp[26]) | s_abs_sat |
                             s_a[26] | s_b[26] | (curve_reg & s_ps[26]) | s_w[26];

    // Temperature path, parabolic whatever the curve setting
    wire [26:0] t_a  = scd_sat(scd_ext(tr) + 4 * scd_ext(c_toff));
    wire [26:0] t_b  = scd_sat(scd_mul(c_tgain, t_a[25:0], scd_pkg::COEF_SHIFT));
    wire [26:0] t_z  = scd_clamp(scd_ext(t_b[25:0]) + scd_pkg::ONE_FRAC, scd_pkg::SAT_MAX);
    wire [26:0] t_c  = scd_sat(scd_mul(c_tso, t_z[25:0], scd_pkg::COEF_SHIFT));
    wire [26:0] t_d  = scd_sat(scd_ext(t_c[25:0]) + scd_pkg::ONE_FRAC);
    wire signed [63:0] t_sum = scd_mul(t_z[25:0], t_d[25:0], scd_pkg::FRAC_SHIFT) +
                               scd_ext(c_tpost);
    wire [26:0] t_w  = scd_clamp(t_sum, scd_pkg::OUT_MAX);
    wire        temp_sat = t_a[26] | t_b[26] | t_z[26] | t_c[26] | t_d[26] | t_w[26];

    // Read mux
    wire [31:0] rd_coef = coef_hit ? {8'h00, coef_reg[coef_idx]} : 32'h00000000;
    wire [31:0] rd_mux =
        (a_sel == scd_pkg::CTRL_OFF)       ? {31'h00000000, curve_reg} :
        (a_sel == scd_pkg::STATUS_OFF)     ? {24'h000000, status_byte} :
        (a_sel == scd_pkg::RAW_SENSOR_OFF) ? {8'h00, raw_sensor_reg} :
        (a_sel == scd_pkg::RAW_TEMP_OFF)   ? {8'h00, raw_temp_reg} :
        (a_sel == scd_pkg::SENSOR_OUT_OFF) ? {8'h00, sensor_result} :
        (a_sel == scd_pkg::TEMP_OUT_OFF)   ? {8'h00, temp_result} :
        (a_sel == scd_pkg::THRESH_ONE_OFF) ? {8'h00, irq_threshold_one} :
        (a_sel == scd_pkg::THRESH_TWO_OFF) ? {8'h00, irq_threshold_two} : rd_coef;

    // Bus phase tracking; reads take one wait state so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hreadyout   <= 1'b1;
            hrdata      <= 32'h00000000;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            rd_pend_reg <= addr_phase & ~hwrite;
            hreadyout   <= ~(addr_phase & ~hwrite);
            hresp       <= 1'b0;
            if (addr_phase) begin
                addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
            end
            if (rd_pend_reg) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_sensor_reg    <= scd_pkg::WORD_RESET;
            raw_temp_reg      <= scd_pkg::WORD_RESET;
            curve_reg         <= 1'b0;
            irq_threshold_one <= scd_pkg::WORD_RESET;
            irq_threshold_two <= scd_pkg::WORD_RESET;
            for (int i = 0; i < scd_pkg::COEF_COUNT; i++) begin
                coef_reg[i] <= scd_pkg::WORD_RESET;
            end
        end else if (wr_data) begin
            if (a_sel == scd_pkg::CTRL_OFF) begin
                curve_reg <= hwdata[scd_pkg::CTRL_CURVE_BIT];
            end
            if (a_sel == scd_pkg::RAW_SENSOR_OFF) begin
                raw_sensor_reg <= hwdata[23:0];
            end
            if (a_sel == scd_pkg::RAW_TEMP_OFF) begin
                raw_temp_reg <= hwdata[23:0];
            end
            // Same unsigned format as results, so a plain compare works
            if (a_sel == scd_pkg::THRESH_ONE_OFF) begin
                irq_threshold_one <= hwdata[23:0];
            end
            if (a_sel == scd_pkg::THRESH_TWO_OFF) begin
                irq_threshold_two <= hwdata[23:0];
            end
            // Full sign-magnitude word kept; range limits are calibration's job
            if (coef_hit) begin
                coef_reg[coef_idx] <= hwdata[23:0];
            end
        end
    end

    // Computation: results latch one cycle after the start write lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_reg     <= 1'b0;
            done_reg      <= 1'b0;
            result_valid  <= 1'b0;
            sensor_result <= scd_pkg::WORD_RESET;
            temp_result   <= scd_pkg::WORD_RESET;
            status_byte   <= scd_pkg::STATUS_RESET;
        end else begin
            start_reg    <= start_wr;
            result_valid <= start_reg;
            if (start_reg) begin
                sensor_result <= s_w[23:0];
                temp_result   <= t_w[23:0];
                done_reg      <= 1'b1;
                status_byte[scd_pkg::STATUS_SAT_BIT]  <= sensor_sat | temp_sat;
                status_byte[scd_pkg::STATUS_DONE_BIT] <= 1'b1;
            end else if (start_wr) begin
                done_reg <= 1'b0;
                status_byte[scd_pkg::STATUS_DONE_BIT] <= 1'b0;
            end
        end
    end

    wire unused_ok = &{1'b0, hsize, done_reg};

endmodule
`default_nettype wire

// ---- rtl/scd_pkg.sv ----
// Constants shared by the sensor correction datapath.
// Assumes a 32-bit AHB-Lite register bus with word aligned registers.
`default_nettype none
package scd_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF        = 8'h00;
    localparam logic [7:0] STATUS_OFF      = 8'h04;
    localparam logic [7:0] RAW_SENSOR_OFF  = 8'h08;
    localparam logic [7:0] RAW_TEMP_OFF    = 8'h0c;
    localparam logic [7:0] COEF_BASE_OFF   = 8'h10;
    localparam logic [7:0] SENSOR_OUT_OFF  = 8'h40;
    localparam logic [7:0] TEMP_OUT_OFF    = 8'h44;
    localparam logic [7:0] THRESH_ONE_OFF  = 8'h48;
    localparam logic [7:0] THRESH_TWO_OFF  = 8'h4c;
    // Coefficient slots, in order from the coefficient base
    localparam int COEF_COUNT              = 12;
    localparam int SENSOR_GAIN_IDX         = 0;
    localparam int SENSOR_OFFSET_IDX       = 1;
    localparam int TEMP_GAIN_DRIFT_IDX     = 2;
    localparam int TEMP_OFFSET_DRIFT_IDX   = 3;
    localparam int TCG_SECOND_IDX          = 4;
    localparam int TCO_SECOND_IDX          = 5;
    localparam int SENSOR_SECOND_IDX       = 6;
    localparam int SENSOR_POST_OFFSET_IDX  = 7;
    localparam int TEMP_GAIN_IDX           = 8;
    localparam int TEMP_OFFSET_IDX         = 9;
    localparam int TEMP_SECOND_IDX         = 10;
    localparam int TEMP_POST_OFFSET_IDX    = 11;
    // Field positions
    localparam int CTRL_CURVE_BIT          = 0;
    localparam int CTRL_START_BIT          = 1;
    localparam int STATUS_SAT_BIT          = 0;
    localparam int STATUS_DONE_BIT         = 1;
    localparam int WORD_MSB                = 23;
    // Arithmetic limits and shifts
    localparam int ACC_W                   = 26;
    localparam int PROD_W                  = 64;
    localparam int COEF_SHIFT              = 21;
    localparam int FRAC_SHIFT              = 23;
    localparam logic signed [63:0] SAT_MAX = 64'sh0000_0000_01ff_ffff;
    localparam logic signed [63:0] SAT_MIN = -64'sh0000_0000_0200_0000;
    localparam logic signed [63:0] OUT_MAX = 64'sh0000_0000_00ff_ffff;
    localparam logic signed [63:0] ONE_FRAC = 64'sh0000_0000_0080_0000;
    // Reset values
    localparam logic [23:0] WORD_RESET     = 24'h000000;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
endpackage
`default_nettype wire

// ---- tb/scd_datapath_props.sv ----
// Concurrent checks on the correction datapath ports.
// Assumes single-word AHB-Lite transfers from one master, hready = hreadyout.
`default_nettype none
module scd_datapath_props (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    // Results
    input wire logic [23:0] sensor_result,
    input wire logic [23:0] temp_result,
    input wire logic [7:0]  status_byte,
    input wire logic        result_valid,
    input wire logic [23:0] irq_threshold_one,
    input wire logic [23:0] irq_threshold_two
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        ph_wr;
    logic [31:0] ph_addr;
    wire logic   taken = hsel & hready & htrans[1];
    wire logic   wr_dp = ph_wr & hready;
    wire logic   start_edge = wr_dp & (ph_addr == 32'h0) & hwdata[scd_pkg::CTRL_START_BIT];
    wire logic   wr_one = wr_dp & (ph_addr == 32'(scd_pkg::THRESH_ONE_OFF));
    wire logic   wr_two = wr_dp & (ph_addr == 32'(scd_pkg::THRESH_TWO_OFF));
    wire logic [23:0] wd_lo = hwdata[23:0];
    // Address phase is remembered so data-phase checks know the target
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_addr <= 32'h0;
        end else if (hready) begin
            ph_wr   <= taken & hwrite;
            ph_addr <= haddr;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_start_latency: assert property (start_edge |-> ##2 result_valid)
        else $error("result not delivered two edges after start");
    chk_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    chk_done_clears: assert property (start_edge |=> !status_byte[1])
        else $error("done bit not cleared by start");
    chk_status_form: assert property (result_valid |-> status_byte[7:1] == 7'h01)
        else $error("status byte malformed at result");
    chk_sat_hold: assert property (!result_valid |-> $stable(status_byte[0]))
        else $error("saturation flag moved between results");
    chk_result_hold: assert property (!result_valid |->
        $stable(sensor_result) && $stable(temp_result))
        else $error("results moved between computations");
    chk_thresh_one: assert property (wr_one |=> irq_threshold_one == $past(wd_lo))
        else $error("threshold one not updated");
    chk_thresh_two: assert property (wr_two |=> irq_threshold_two == $past(wd_lo))
        else $error("threshold two not updated");
    chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:24] == 8'h00)
        else $error("read data above the 24-bit word not zero");
endmodule
bind scd_datapath scd_datapath_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .sensor_result(sensor_result),
    .temp_result(temp_result), .status_byte(status_byte), .result_valid(result_valid),
    .irq_threshold_one(irq_threshold_one), .irq_threshold_two(irq_threshold_two));
`default_nettype wire

// ---- tb/scd_host_link.sv ----
// Host side of the result path: keeps the last word set handed over.
// Assumes result_valid is a one-cycle pulse in the hclk domain.
`default_nettype none
module scd_host_link (
    // Clock and reset
    input wire logic         hclk,
    input wire logic         hresetn,
    // Results from the datapath
    input wire logic         result_valid,
    input wire logic [23:0]  sensor_result,
    input wire logic [23:0]  temp_result,
    // Captured words
    output logic [23:0]      host_sensor,
    output logic [23:0]      host_temp,
    output int               host_count
);
    timeunit 1ns;
    timeprecision 100ps;
    // Words are taken only on the pulse, so a stale word can not pass twice
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_sensor <= 24'h000000;
            host_temp   <= 24'h000000;
            host_count  <= 0;
        end else if (result_valid) begin
            host_sensor <= sensor_result;
            host_temp   <= temp_result;
            host_count  <= host_count + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sensor_correction_datapath_test.sv ----
// Self-checking bench: random readings and coefficients against an integer model.
// Assumes the datapath answers writes with no wait and reads with one.
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sensor_correction_datapath_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam longint HI = 33554431;
    localparam longint LO = -33554432;
    localparam longint ONE = 8388608;
    localparam longint OMAX = 16777215;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, result_valid, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [23:0] sensor_result, temp_result, thr_one, thr_two, host_sensor, host_temp;
    logic [23:0] raw_s, raw_t;
    logic [23:0] cf [12];
    logic [7:0]  status_byte;
    int          n_fail, comparisons, cycles, host_count, k;
    integer      seed = 32'h0b90;
    bit          sat_hit, big;
    longint      es, et;
    scd_datapath DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_result(sensor_result),
        .temp_result(temp_result), .status_byte(status_byte), .result_valid(result_valid),
        .irq_threshold_one(thr_one), .irq_threshold_two(thr_two));
    scd_host_link u_host (.hclk(hclk), .hresetn(hresetn), .result_valid(result_valid),
        .sensor_result(sensor_result), .temp_result(temp_result), .host_sensor(host_sensor),
        .host_temp(host_temp), .host_count(host_count));
    always #10 hclk = ~hclk;
    task wrap_up;
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // A hang in a bus wait ends here rather than running forever
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic longint lim(longint x, longint lo = LO, longint hi = HI);
        if (x > hi || x < lo) sat_hit = 1'b1;
        return x > hi ? hi : (x < lo ? lo : x);
    endfunction
    function automatic longint c(int i);
        return cf[i][23] ? -longint'(cf[i][22:0]) : longint'(cf[i][22:0]);
    endfunction
    // Shifts on longint truncate toward minus infinity, as the datapath does
    task automatic model(input bit crv);
        longint tr, k1, k2, p, z, q;
        sat_hit = 1'b0;
        tr = longint'($signed(raw_t));
        k1 = lim(ONE + lim((tr * lim(lim((c(4) * tr) >>> 21) + 4 * c(2))) >>> 23));
        k2 = lim((tr * lim(lim((c(5) * tr) >>> 21) + 4 * c(3))) >>> 23);
        k2 = lim(4 * c(1) + lim(longint'($signed(raw_s)) + k2));
        p = lim((k1 * k2) >>> 23);
        z = lim(((c(0) * p) >>> 21) + (crv ? 0 : ONE));
        q = lim(lim((c(6) * (crv ? lim(z < 0 ? -z : z) : z)) >>> 21) + ONE);
        if (crv)
            es = lim(lim((z * q) >>> 23) + ONE + c(7), 0, OMAX);
        else
            es = lim(((z * q) >>> 23) + c(7), 0, OMAX);
        z = lim(lim((c(8) * lim(tr + 4 * c(9))) >>> 21) + ONE, 0, HI);
        q = lim(lim((c(10) * z) >>> 21) + ONE);
        et = lim(((z * q) >>> 23) + c(11), 0, OMAX);
    endtask
    initial begin
        hclk = 0; hresetn = 0; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
        hwdata = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK("status_reset", 8'h00, status_byte);
        `CHK("sensor_reset", 24'h000000, sensor_result);
        for (int i = 0; i < 60; i++) begin
            big = (i % 3 == 2);
            v = $random(seed);
            raw_s = big ? v[23:0] : {{4{v[19]}}, v[19:0]};
            v = $random(seed);
            raw_t = big ? v[23:0] : {{4{v[19]}}, v[19:0]};
            bus(1'b1, 32'(scd_pkg::RAW_SENSOR_OFF), {8'h00, raw_s});
            bus(1'b1, 32'(scd_pkg::RAW_TEMP_OFF), {8'h00, raw_t});
            for (int j = 0; j < scd_pkg::COEF_COUNT; j++) begin
                v = $random(seed);
                cf[j] = {v[31], v[22:0] & (big ? 23'h7fffff : 23'h07ffff)};
                bus(1'b1, 32'(scd_pkg::COEF_BASE_OFF) + 32'(4 * j), {8'h00, cf[j]});
            end
            bus(1'b1, 32'h0, {30'h0, 1'b1, 1'(i % 2)});
            k = 0;
            do begin
                @(posedge hclk);
                k++;
            end while (result_valid !== 1'b1 && k < 8);
            model(1'(i % 2));
            `CHK("latency", 2, k);
            `CHK("sensor", 24'(es), sensor_result);
            `CHK("temp", 24'(et), temp_result);
            `CHK("status", {6'h00, 1'b1, sat_hit}, status_byte);
            bus(1'b0, 32'(scd_pkg::SENSOR_OUT_OFF), 32'h0);
            `CHK("sensor_read", {8'h00, 24'(es)}, rd);
            bus(1'b0, 32'(scd_pkg::TEMP_OUT_OFF), 32'h0);
            `CHK("temp_read", {8'h00, 24'(et)}, rd);
            `CHK("hresp", 1'b0, hresp);
            `CHK("host_sensor", 24'(es), host_sensor);
            `CHK("host_temp", 24'(et), host_temp);
            `CHK("host_count", i + 1, host_count);
        end
        v = $random(seed);
        bus(1'b1, 32'(scd_pkg::THRESH_ONE_OFF), v);
        bus(1'b1, 32'(scd_pkg::THRESH_TWO_OFF), ~v);
        bus(1'b0, 32'(scd_pkg::THRESH_ONE_OFF), 32'h0);
        `CHK("thr_one_read", {8'h00, v[23:0]}, rd);
        `CHK("thr_two", ~v[23:0], thr_two);
        bus(1'b0, 32'h0000_0100, 32'h0);
        `CHK("unmapped", 32'h0, rd);
        bus(1'b0, 32'h0, 32'h0);
        `CHK("ctrl_read", 32'h1, rd);
        wrap_up();
    end
endmodule
`undef CHK
`default_nettype wire
